// ---- design/nvmseq_top.sv ----
`timescale 1ns/1ps
// Behaviour
// (R1) Program memory is erased or programmed one 32-word row at a time.
// (R2) Row erase: software writes op 011000 with erase and write enable.
// (R3) Key register must see 55h then AAh before a start.
// (R4) Start bit begins the cycle; processor stall is held throughout.
// (R5) Start bit clears itself when the cycle ends.
// (R6) Row program: op 011000, erase clear, write enable set.
// (R7) No operation proceeds without the unlock pair first.
// (R8) Software places two no-ops after setting the start bit.
// (R9) Software sets the row address via table pointer before erase.
// (R10) Bulk erase affects all data EEPROM, needing no address.
// (R11) Completion shows as start clearing and done flag setting.
// (R12) Control resets to 0000 on power-on reset.
// (R13) Row erase control word is 0x4058.
// (R14) Software blocks interrupts for five instructions around the unlock.
// (R15) Software may clear the done flag before an EEPROM operation.
// (R16) EEPROM word program uses op pattern 0001xx.
// (R17) With program-only set, software erases the word first.
// (R18) A start without valid unlock leaves memory unchanged and flags error; while a cycle runs the code ignores such a start and sets no error.
module nvmseq_top #(
  parameter int OP_CYCLES = nvmseq_pkg::NVMSEQ_OP_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire nvmseq_pkg::nvmseq_apb_req_t APB_REQ,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic CPU_STALL,
  output logic NVM_DONE_FLAG,
  output logic MEM_OP_PULSE,
  output logic [6:0] MEM_OP_CODE
);
  import nvmseq_pkg::*;

  typedef struct packed {
    logic [15:0] control;
    nvmseq_key_t key;
    nvmseq_op_t op;
    logic [15:0] count;
    logic done;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic op_pulse;
    logic [6:0] op_code;
    logic stall;
  } nvmseq_state_t;

  nvmseq_state_t state_ff;
  nvmseq_state_t nxt_state;
  logic wr_acc;
  logic rd_acc;
  logic hit_ctl;
  logic hit_key;
  logic hit_sts;
  logic [15:0] wdat;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode: an access is taken once, in its first access cycle, and answered in
  // the next, so every access phase lasts two cycles.
  // The ready gate keeps a held request from being taken twice; a second AAh write
  // would otherwise cancel the armed pair.
  always_comb begin
    wr_acc = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && !state_ff.ready;
    rd_acc = APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite && !state_ff.ready;
    hit_ctl = APB_REQ.paddr == {14'h0000, NVMSEQ_ADR_CONTROL};
    hit_key = APB_REQ.paddr == {14'h0000, NVMSEQ_ADR_KEY};
    hit_sts = APB_REQ.paddr == {14'h0000, NVMSEQ_ADR_STATUS};
    wdat = APB_REQ.pwdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state of registers, key sequencer and operation timer.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.ready = 1'b0;
    nxt_state.slverr = 1'b0;
    nxt_state.op_pulse = 1'b0;
    nxt_state.rdata = 32'h0000_0000;
    // Read data; the key register reads as zero.
    if (rd_acc) begin
      nxt_state.ready = 1'b1;
      if (hit_ctl) begin
        nxt_state.rdata = {16'h0000, state_ff.control};
      end else if (hit_key) begin
        nxt_state.rdata = 32'h0000_0000;
      end else if (hit_sts) begin
        nxt_state.rdata = {31'h0000_0000, state_ff.done};
      end else begin
        nxt_state.slverr = 1'b1;
      end
    end
    // Key writes: only 55h followed directly by AAh arms a start.
    // A repeated 55h restarts the pair instead of cancelling it.
    if (wr_acc && hit_key) begin
      if (wdat[7:0] == NVMSEQ_KEY_FIRST) begin
        nxt_state.key = NVMSEQ_KEY1; // R3
      end else if (wdat[7:0] == NVMSEQ_KEY_SECOND && state_ff.key == NVMSEQ_KEY1) begin
        nxt_state.key = NVMSEQ_ARMED; // R3
      end else begin
        nxt_state.key = NVMSEQ_IDLE;
      end
    end else if (wr_acc) begin
      // Any other write breaks the key pair, the start itself below included.
      nxt_state.key = NVMSEQ_IDLE;
    end
    if (wr_acc) begin
      nxt_state.ready = 1'b1;
      if (!(hit_ctl || hit_key || hit_sts)) begin
        nxt_state.slverr = 1'b1;
      end
    end
    // Control writes are ignored while a cycle runs.
    if (wr_acc && hit_ctl && state_ff.op == NVMSEQ_READY) begin
      nxt_state.control = (state_ff.control & ~NVMSEQ_CONTROL_WMASK) |
                          (wdat & NVMSEQ_CONTROL_WMASK);
      if (!wdat[NVMSEQ_BIT_ERR]) begin
        nxt_state.control[NVMSEQ_BIT_ERR] = 1'b0;
      end
      if (wdat[NVMSEQ_BIT_START]) begin
        if (state_ff.key == NVMSEQ_ARMED && wdat[NVMSEQ_BIT_WRITE_EN]) begin
          // Start accepted: op code and erase bit pass to the array. R4 R7 R1 R10
          nxt_state.control[NVMSEQ_BIT_START] = 1'b1;
          nxt_state.op = NVMSEQ_BUSY;
          nxt_state.count = 16'(OP_CYCLES - 1);
          nxt_state.op_pulse = 1'b1;
          nxt_state.op_code = {wdat[NVMSEQ_BIT_ERASE], wdat[5:0]};
        end else begin
          nxt_state.control[NVMSEQ_BIT_ERR] = 1'b1; // R18
        end
      end
    end
    // Done flag: software clears by writing 0 to status bit 0, a finish wins. R11
    if (wr_acc && hit_sts && !wdat[0]) begin
      nxt_state.done = 1'b0;
    end
    // Operation timer; the start bit clears itself at the end. R5 R11
    if (state_ff.op == NVMSEQ_BUSY) begin
      if (state_ff.count == 16'h0000) begin
        nxt_state.op = NVMSEQ_READY;
        nxt_state.control[NVMSEQ_BIT_START] = 1'b0; // R5
        nxt_state.done = 1'b1; // R11
      end else begin
        nxt_state.count = state_ff.count - 16'h0001;
      end
    end
    // The stall output has its own flip-flop and follows the operation state.
    // Counting down from OP_CYCLES - 1 keeps it high for exactly OP_CYCLES cycles.
    nxt_state.stall = nxt_state.op == NVMSEQ_BUSY; // R4
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; synchronous reset to power-on values.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_ff <= '0;
      state_ff.control <= NVMSEQ_CONTROL_RESET; // R12
      state_ff.key <= NVMSEQ_IDLE;
      state_ff.op <= NVMSEQ_READY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from the state register.
  always_comb begin
    PRDATA = state_ff.rdata;
    PREADY = state_ff.ready;
    PSLVERR = state_ff.slverr;
    CPU_STALL = state_ff.stall; // R4
    NVM_DONE_FLAG = state_ff.done;
    MEM_OP_PULSE = state_ff.op_pulse;
    MEM_OP_CODE = state_ff.op_code;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the key sequencer, the flash cycle timing and the done flag.
  // They watch the outputs, the state register and the decoded bus access of this block.
  a_start_needs_key: assert property (@(posedge CLK) disable iff (!RST_N) // R7
    $rose(CPU_STALL) |-> $past(state_ff.key) == NVMSEQ_ARMED)
    else $error("Cycle started without unlock pair.");
  a_stall_length: assert property (@(posedge CLK) disable iff (!RST_N) // R4
    $fell(CPU_STALL) |-> $past(CPU_STALL, OP_CYCLES) && !$past(CPU_STALL, OP_CYCLES + 1))
    else $error("Stall length differs from the cycle length.");
  a_start_self_clear: assert property (@(posedge CLK) disable iff (!RST_N) // R5
    $fell(CPU_STALL) |-> !state_ff.control[NVMSEQ_BIT_START])
    else $error("Start bit not cleared at end of cycle.");
  a_done_on_finish: assert property (@(posedge CLK) disable iff (!RST_N) // R11
    $fell(CPU_STALL) |-> NVM_DONE_FLAG)
    else $error("Done flag not set at end of cycle.");
  a_bad_start_error: assert property (@(posedge CLK) disable iff (!RST_N) // R18
    (wr_acc && hit_ctl && wdat[NVMSEQ_BIT_START] && state_ff.key != NVMSEQ_ARMED &&
     state_ff.op == NVMSEQ_READY) |=> state_ff.control[NVMSEQ_BIT_ERR] && !CPU_STALL)
    else $error("Unkeyed start not refused.");
  a_pulse_with_stall: assert property (@(posedge CLK) disable iff (!RST_N) // R4
    MEM_OP_PULSE |-> CPU_STALL)
    else $error("Array pulse without stall.");
  a_key_order: assert property (@(posedge CLK) disable iff (!RST_N) // R3
    (state_ff.key == NVMSEQ_ARMED && $past(state_ff.key) != NVMSEQ_ARMED)
    |-> $past(state_ff.key) == NVMSEQ_KEY1)
    else $error("Armed without first key.");
  a_reset_value: assert property (@(posedge CLK) // R12
    !$past(RST_N) |-> state_ff.control == NVMSEQ_CONTROL_RESET)
    else $error("Control not reset.");
  a_start_eats_key: assert property (@(posedge CLK) disable iff (!RST_N) // R7
    MEM_OP_PULSE |-> state_ff.key != NVMSEQ_ARMED)
    else $error("Unlock pair left armed after a start.");
  a_code_hold: assert property (@(posedge CLK) disable iff (!RST_N) // R1
    !MEM_OP_PULSE |-> $stable(MEM_OP_CODE))
    else $error("Operation code changed without a start.");
  a_done_sticky: assert property (@(posedge CLK) disable iff (!RST_N) // R11
    (NVM_DONE_FLAG && !(wr_acc && hit_sts && !wdat[0])) |=> NVM_DONE_FLAG)
    else $error("Done flag dropped without a clear.");
  // Cover points for the main kinds of flash cycle and for a refused start.
  c_row_erase: cover property (@(posedge CLK) MEM_OP_PULSE && MEM_OP_CODE == 7'h58);
  c_bulk_erase: cover property (@(posedge CLK) MEM_OP_PULSE && MEM_OP_CODE == 7'h50);
  c_bad_start: cover property (@(posedge CLK) $rose(state_ff.control[NVMSEQ_BIT_ERR]));
  c_row_program: cover property (@(posedge CLK) MEM_OP_PULSE && MEM_OP_CODE == 7'h18);
  c_word_program: cover property (@(posedge CLK)
    MEM_OP_PULSE && !MEM_OP_CODE[6] && MEM_OP_CODE[5:2] == NVMSEQ_OP_WORD_HI);

endmodule : nvmseq_top

// ---- design/nvmseq_pkg.sv ----
package nvmseq_pkg;

  // Register indices; 0x0766 is not word aligned, so each register sits at the byte
  // address four times its index.
  localparam logic [15:0] NVMSEQ_IDX_CONTROL = 16'h0760;
  localparam logic [15:0] NVMSEQ_IDX_KEY = 16'h0766;
  localparam logic [15:0] NVMSEQ_IDX_STATUS = 16'h0768;
  localparam logic [17:0] NVMSEQ_ADR_CONTROL = {NVMSEQ_IDX_CONTROL, 2'b00};
  localparam logic [17:0] NVMSEQ_ADR_KEY = {NVMSEQ_IDX_KEY, 2'b00};
  localparam logic [17:0] NVMSEQ_ADR_STATUS = {NVMSEQ_IDX_STATUS, 2'b00};

  // Control field positions.
  localparam int NVMSEQ_BIT_START = 15;
  localparam int NVMSEQ_BIT_WRITE_EN = 14;
  localparam int NVMSEQ_BIT_ERR = 13;
  localparam int NVMSEQ_BIT_PROG_ONLY = 12;
  localparam int NVMSEQ_BIT_ERASE = 6;
  localparam logic [15:0] NVMSEQ_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] NVMSEQ_CONTROL_WMASK = 16'h507F;

  // Key values and operation codes.
  localparam logic [7:0] NVMSEQ_KEY_FIRST = 8'h55;
  localparam logic [7:0] NVMSEQ_KEY_SECOND = 8'hAA;
  localparam logic [5:0] NVMSEQ_OP_ROW = 6'h18;
  localparam logic [5:0] NVMSEQ_OP_BULK = 6'h10;
  localparam logic [3:0] NVMSEQ_OP_WORD_HI = 4'h1;
  localparam int NVMSEQ_ROW_WORDS = 32;

  // Cycle length of a flash operation.
  localparam int NVMSEQ_CLK_MHZ = 40;
  localparam int NVMSEQ_OP_TIME_US = 2;
  localparam int NVMSEQ_OP_CYCLES = NVMSEQ_OP_TIME_US * NVMSEQ_CLK_MHZ;

  typedef enum logic [1:0] {NVMSEQ_IDLE, NVMSEQ_KEY1, NVMSEQ_ARMED} nvmseq_key_t;
  typedef enum logic [1:0] {NVMSEQ_READY, NVMSEQ_BUSY} nvmseq_op_t;

  // APB request carrier.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } nvmseq_apb_req_t;

endpackage : nvmseq_pkg

// ---- tb/nvmseq_cpu.sv ----
`timescale 1ns/1ps
// Processor model: it runs the software sequences as APB transfers.
module nvmseq_cpu (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output nvmseq_pkg::nvmseq_apb_req_t apb_req
);
  import nvmseq_pkg::*;
  initial apb_req = '0;
  ////////////////////////////////////////////////////////////
  // One transfer. The request holds until pready is seen, then the bus is
  // released with inverted address and data, so stale values never pass.
  // The wait has no limit of its own; the bench watchdog ends a hang.
  task automatic apb(input logic w, input logic [17:0] a, input logic [15:0] d,
                     output logic [31:0] q, output logic e);
    apb_req <= '{1'b1, 1'b0, w, {14'h0000, a}, {16'h0000, d}};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb_req <= '{1'b0, 1'b0, ~w, ~{14'h0000, a}, ~{16'h0000, d}};
    @(posedge clk);
  endtask : apb
  // Set-up write, the ordered key pair, then the start write.
  task automatic unlock_start(input logic [15:0] ctl);
    logic [31:0] q;
    logic e;
    // The row address reaches the array through the table page pointer, outside here.
    apb(1'b1, NVMSEQ_ADR_CONTROL, ctl & 16'h7FFF, q, e);
    apb(1'b1, NVMSEQ_ADR_KEY, 16'h0055, q, e);
    apb(1'b1, NVMSEQ_ADR_KEY, 16'h00AA, q, e);
    apb(1'b1, NVMSEQ_ADR_CONTROL, ctl, q, e);
    repeat (2) @(posedge clk);
  endtask : unlock_start
endmodule : nvmseq_cpu

// ---- tb/nvmseq_top_tb.sv ----
`timescale 1ns/1ps
module nvmseq_top_tb;
  import nvmseq_pkg::*;
  localparam int OPC = 4;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  nvmseq_apb_req_t APB_REQ;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, CPU_STALL, NVM_DONE_FLAG, MEM_OP_PULSE;
  logic [6:0] MEM_OP_CODE;
  int errors = 0;
  int n_tests = 0;
  int pulses = 0;
  int stalls = 0;
  logic [31:0] q;
  logic e;
  logic [15:0] ops [6] = '{16'hC058, 16'hC018, 16'hC050, 16'hC004, 16'hC044, 16'hD004};
  // The clock toggles every half period.
  always #12.5 CLK = ~CLK;
  // Start pulses and stalled cycles are counted at each rising edge.
  always @(posedge CLK) begin
    if (MEM_OP_PULSE === 1'b1) pulses++;
    if (CPU_STALL === 1'b1) stalls++;
  end
  nvmseq_top #(.OP_CYCLES(OPC)) nvmseq_top_i (.CLK(CLK), .RST_N(RST_N), .APB_REQ(APB_REQ),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CPU_STALL(CPU_STALL),
    .NVM_DONE_FLAG(NVM_DONE_FLAG), .MEM_OP_PULSE(MEM_OP_PULSE), .MEM_OP_CODE(MEM_OP_CODE));
  nvmseq_cpu nvmseq_cpu_i (.clk(CLK), .pready(PREADY), .pslverr(PSLVERR), .prdata(PRDATA),
    .apb_req(APB_REQ));
  ////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // Reset values, the write-only key and an unmapped address.
  task automatic t_reset();
    nvmseq_cpu_i.apb(1'b0, NVMSEQ_ADR_CONTROL, 16'h0000, q, e);
    chk("control reset", 32'h0000_0000, q);
    nvmseq_cpu_i.apb(1'b0, NVMSEQ_ADR_KEY, 16'h0000, q, e);
    chk("key read", 32'h0000_0000, q);
    nvmseq_cpu_i.apb(1'b0, 18'h00004, 16'h0000, q, e);
    chk("unmapped error", 32'h0000_0001, {31'h0, e});
    $display("test reset done");
  endtask : t_reset
  // A keyed operation: stall length, code, self-clearing start and done flag.
  task automatic t_op(input logic [15:0] ctl);
    int n;
    int p;
    int s;
    n = 0;
    nvmseq_cpu_i.apb(1'b1, NVMSEQ_ADR_STATUS, 16'h0000, q, e);
    chk("done cleared", 32'h0, {31'h0, NVM_DONE_FLAG});
    p = pulses;
    s = stalls;
    nvmseq_cpu_i.unlock_start(ctl);
    #1;
    chk("op code", {25'h0, ctl[6:0]}, {25'h0, MEM_OP_CODE});
    while (CPU_STALL === 1'b1 && n < 100) begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk("stall cycles", OPC, stalls - s);
    chk("pulse count", p + 1, pulses);
    chk("done flag", 32'h1, {31'h0, NVM_DONE_FLAG});
    @(posedge CLK);
    nvmseq_cpu_i.apb(1'b0, NVMSEQ_ADR_CONTROL, 16'h0000, q, e);
    chk("start cleared", {16'h0, ctl & 16'h7FFF}, q);
    $display("test op %h done", ctl);
  endtask : t_op
  // A key pair broken by another write must not start anything.
  task automatic t_nokey();
    int p;
    p = pulses;
    nvmseq_cpu_i.apb(1'b1, NVMSEQ_ADR_KEY, 16'h0055, q, e);
    nvmseq_cpu_i.apb(1'b1, NVMSEQ_ADR_CONTROL, 16'h4058, q, e);
    nvmseq_cpu_i.apb(1'b1, NVMSEQ_ADR_KEY, 16'h00AA, q, e);
    nvmseq_cpu_i.apb(1'b1, NVMSEQ_ADR_CONTROL, 16'hC058, q, e);
    repeat (OPC + 2) @(posedge CLK);
    chk("no start", p, pulses);
    chk("no stall", 32'h0, {31'h0, CPU_STALL});
    nvmseq_cpu_i.apb(1'b0, NVMSEQ_ADR_CONTROL, 16'h0000, q, e);
    chk("error bit", 32'h1, {30'h0, q[15], q[13]});
    $display("test unkeyed done");
  endtask : t_nokey
  // Main sequence.
  initial begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    t_reset();
    foreach (ops[i]) t_op(ops[i]);
    t_nokey();
    tally_and_finish();
  end
  // Watchdog against a hang.
  initial begin
    #(25 * 5000);
    errors++;
    tally_and_finish();
  end
endmodule : nvmseq_top_tb
